// >>> logic/scc_pkg.sv
// Constants for the command control input front end
package scc_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] SCC_MODE_OFS = 8'h00;
    localparam logic [7:0] SCC_STAT_OFS = 8'h04;
    localparam logic [31:0] SCC_MODE_RST = 32'h0000_0221;
    // Mode register fields
    localparam int SCC_TERM_EN_BIT = 0;
    localparam int SCC_AL_LSB = 1;
    localparam int SCC_BURST_LSB = 3;
    localparam int SCC_RL_LSB = 5;
    localparam int SCC_MODE_W = 10;
    // Status word fields
    localparam int SCC_ST_BANKS_LSB = 0;
    localparam int SCC_ST_PWR_LSB = 16;
    localparam int SCC_ST_TERM_BIT = 20;
    localparam int SCC_ST_ROW_LSB = 21;
    localparam int SCC_ST_ACT_LSB = 24;
    // Additive latency selections
    localparam logic [1:0] SCC_AL_ZERO = 2'h0;
    localparam logic [1:0] SCC_AL_RL1 = 2'h1;
    localparam logic [1:0] SCC_AL_RL2 = 2'h2;
    // Burst selections
    localparam logic [1:0] SCC_BURST_FIX8 = 2'h0;
    localparam logic [1:0] SCC_BURST_OTF = 2'h1;
    localparam logic [1:0] SCC_BURST_FIX4 = 2'h2;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        SCC_PWR_ON = 4'b0001,
        SCC_PWR_PPD = 4'b0010,
        SCC_PWR_APD = 4'b0100,
        SCC_PWR_SREF = 4'b1000
    } scc_pwr_t;
    typedef enum logic [2:0] {
        SCC_CMD_MRS = 3'h0,
        SCC_CMD_REF = 3'h1,
        SCC_CMD_PRE = 3'h2,
        SCC_CMD_RSV = 3'h3,
        SCC_CMD_WR = 3'h4,
        SCC_CMD_RD = 3'h5,
        SCC_CMD_ZQ = 3'h6,
        SCC_CMD_NOP = 3'h7
    } scc_cmd_t;
    localparam int SCC_BANKS = 16;
    localparam int SCC_GROUPS = 4;
endpackage : scc_pkg

// >>> logic/scc_top.sv
// Command, clock-enable and termination input front end
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Inputs captured at true clock rising edge
// - Clock enable gates clocks, buffers, drivers
// - Enable low: idle power-down/self refresh, else active
// - Self refresh exit on asynchronous enable rise
// - Power-down keeps clock, termination, enable buffers
// - Self refresh keeps only enable buffer
// - Rank select high masks command
// - Rank select is part of command code
// - Termination input high applies nominal termination
// - Mode disables termination: input ignored
// - Activate low: pins are row bits 16..14
// - Activate high: pins are command bits
// - Sixteen banks: four groups of four
// - Additive latency zero, RL-1 or RL-2
// - Eight-beat, chopped four, or on the fly
// - Reset active low, asynchronous
module scc_top import scc_pkg::*; #(
    parameter int ROW_W = 17
) (
    // AHB-Lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Memory clock pins
    input wire logic mem_clk,
    input wire logic clock_complement,
    // Control and address pins
    input wire logic clock_gate,
    input wire logic rank_select_n,
    input wire logic activate_input_n,
    input wire logic row_strobe_or_addr16,
    input wire logic column_strobe_or_addr15,
    input wire logic write_cmd_or_addr14,
    input wire logic termination_enable_in,
    input wire logic [1:0] bank_group,
    input wire logic [1:0] bank_addr,
    input wire logic [13:0] addr,
    // Internal enables
    output logic int_clk_en,
    output logic cmd_buf_en,
    output logic clk_buf_en,
    output logic term_buf_en,
    output logic out_drv_en,
    output logic term_applied,
    // Decoded commands
    output logic cmd_activate,
    output logic cmd_read,
    output logic cmd_write,
    output logic cmd_precharge,
    output logic cmd_refresh,
    output logic cmd_mode_set,
    output logic burst_chop,
    output logic [ROW_W-1:0] act_row,
    output logic [3:0] act_bank,
    output logic [4:0] additive_latency
);
    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [3:0] bank_idx(input logic [1:0] g,
                                            input logic [1:0] b);
        bank_idx = {g, b};
    endfunction : bank_idx

    function automatic logic [4:0] al_value(input logic [1:0] sel,
                                            input logic [4:0] rl);
        case (sel)
            SCC_AL_RL1: al_value = rl - 5'h01;
            SCC_AL_RL2: al_value = rl - 5'h02;
            default: al_value = 5'h00;
        endcase
    endfunction : al_value

    // ****************************************
    // Link reset and crossings
    // ****************************************
    logic lrst_a_reg, lrst_n_reg;
    always_ff @(posedge mem_clk or negedge hresetn) begin
        if (!hresetn) begin
            lrst_a_reg <= 1'b0;
            lrst_n_reg <= 1'b0;
        end else begin
            lrst_a_reg <= 1'b1;
            lrst_n_reg <= lrst_a_reg;
        end
    end

    // Self refresh exit toggles without the memory clock
    logic sre_tgl_reg;
    always_ff @(posedge clock_gate or negedge hresetn) begin
        if (!hresetn) begin
            sre_tgl_reg <= 1'b0;
        end else begin
            sre_tgl_reg <= ~sre_tgl_reg;
        end
    end

    logic [SCC_MODE_W-1:0] mode_reg, lmode_reg;
    logic mode_tgl_reg;
    logic [2:0] mtgl_sync_reg;
    logic [2:0] sre_sync_reg;
    always_ff @(posedge mem_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            mtgl_sync_reg <= 3'h0;
            sre_sync_reg <= 3'h0;
        end else begin
            mtgl_sync_reg <= {mtgl_sync_reg[1:0], mode_tgl_reg};
            sre_sync_reg <= {sre_sync_reg[1:0], sre_tgl_reg};
        end
    end

    always_ff @(posedge mem_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            lmode_reg <= SCC_MODE_RST[SCC_MODE_W-1:0];
        end else if (mtgl_sync_reg[2] != mtgl_sync_reg[1]) begin
            lmode_reg <= mode_reg;
        end
    end

    // ****************************************
    // Pin capture
    // ****************************************
    logic cke_q, cs_n_q, act_n_q, odt_q;
    logic [2:0] mf_q;
    logic [1:0] bg_q, ba_q;
    logic [13:0] addr_q;
    always_ff @(posedge mem_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            cke_q <= 1'b0;
            cs_n_q <= 1'b1;
            act_n_q <= 1'b1;
            odt_q <= 1'b0;
            mf_q <= 3'h7;
            bg_q <= 2'h0;
            ba_q <= 2'h0;
            addr_q <= 14'h0000;
        end else begin
            cke_q <= clock_gate;
            cs_n_q <= rank_select_n;
            act_n_q <= activate_input_n;
            odt_q <= termination_enable_in;
            mf_q <= {row_strobe_or_addr16, column_strobe_or_addr15,
                     write_cmd_or_addr14};
            bg_q <= bank_group;
            ba_q <= bank_addr;
            addr_q <= addr;
        end
    end

    // ****************************************
    // Command decode
    // ****************************************
    scc_pwr_t pwr_reg;
    logic cke_prev_reg;
    logic live;
    logic is_act;
    scc_cmd_t cmd;
    assign live = (pwr_reg == SCC_PWR_ON) && cke_prev_reg;
    assign is_act = live && !cs_n_q && !act_n_q;
    assign cmd = scc_cmd_t'(mf_q);

    logic sel_cmd;
    assign sel_cmd = live && !cs_n_q && act_n_q;

    logic [SCC_BANKS-1:0] open_reg;
    logic [7:0] act_cnt_reg;
    always_ff @(posedge mem_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            cmd_activate <= 1'b0;
            cmd_read <= 1'b0;
            cmd_write <= 1'b0;
            cmd_precharge <= 1'b0;
            cmd_refresh <= 1'b0;
            cmd_mode_set <= 1'b0;
            burst_chop <= 1'b0;
            act_row <= '0;
            act_bank <= 4'h0;
        end else begin
            cmd_activate <= is_act;
            cmd_read <= sel_cmd && cmd == SCC_CMD_RD;
            cmd_write <= sel_cmd && cmd == SCC_CMD_WR;
            cmd_precharge <= sel_cmd && cmd == SCC_CMD_PRE;
            cmd_refresh <= sel_cmd && cmd == SCC_CMD_REF && cke_q;
            cmd_mode_set <= sel_cmd && cmd == SCC_CMD_MRS;
            if (sel_cmd && (cmd == SCC_CMD_RD || cmd == SCC_CMD_WR)) begin
                case (lmode_reg[SCC_BURST_LSB +: 2])
                    SCC_BURST_FIX4: burst_chop <= 1'b1;
                    SCC_BURST_OTF: burst_chop <= !addr_q[12];
                    default: burst_chop <= 1'b0;
                endcase
            end
            if (is_act) begin
                act_row <= ROW_W'({mf_q, addr_q});
                act_bank <= bank_idx(bg_q, ba_q);
            end
        end
    end

    always_ff @(posedge mem_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            open_reg <= '0;
            act_cnt_reg <= 8'h00;
        end else if (is_act) begin
            open_reg[bank_idx(bg_q, ba_q)] <= 1'b1;
            act_cnt_reg <= act_cnt_reg + 8'h01;
        end else if (sel_cmd && cmd == SCC_CMD_PRE) begin
            if (addr_q[10]) begin
                open_reg <= '0;
            end else begin
                open_reg[bank_idx(bg_q, ba_q)] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mem_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            additive_latency <= 5'h00;
        end else begin
            additive_latency <= al_value(lmode_reg[SCC_AL_LSB +: 2],
                                         lmode_reg[SCC_RL_LSB +: 5]);
        end
    end

    // ****************************************
    // Power state
    // ****************************************
    always_ff @(posedge mem_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            pwr_reg <= SCC_PWR_ON;
            cke_prev_reg <= 1'b0;
        end else begin
            cke_prev_reg <= cke_q;
            case (pwr_reg)
                SCC_PWR_ON: begin
                    if (cke_prev_reg && !cke_q) begin
                        if (!cs_n_q && act_n_q && cmd == SCC_CMD_REF
                            && open_reg == '0) begin
                            pwr_reg <= SCC_PWR_SREF;
                        end else if (open_reg != '0) begin
                            pwr_reg <= SCC_PWR_APD;
                        end else begin
                            pwr_reg <= SCC_PWR_PPD;
                        end
                    end
                end
                SCC_PWR_PPD, SCC_PWR_APD: begin
                    if (cke_q) begin
                        pwr_reg <= SCC_PWR_ON;
                    end
                end
                SCC_PWR_SREF: begin
                    if (sre_sync_reg[2] != sre_sync_reg[1]) begin
                        pwr_reg <= SCC_PWR_ON;
                    end
                end
                default: pwr_reg <= SCC_PWR_ON;
            endcase
        end
    end


    // ****************************************
    // Buffer and termination enables
    // ****************************************
    assign int_clk_en = cke_q && pwr_reg == SCC_PWR_ON;
    assign cmd_buf_en = pwr_reg == SCC_PWR_ON;
    assign out_drv_en = pwr_reg == SCC_PWR_ON;
    assign clk_buf_en = pwr_reg != SCC_PWR_SREF;
    assign term_buf_en = pwr_reg != SCC_PWR_SREF;

    always_ff @(posedge mem_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            term_applied <= 1'b0;
        end else begin
            term_applied <= odt_q && term_buf_en
                && lmode_reg[SCC_TERM_EN_BIT];
        end
    end

    // ****************************************
    // Status crossing by handshake
    // ****************************************
    logic [31:0] live_stat, shadow_reg, hstat_reg;
    logic sreq_reg, sack_reg;
    logic [1:0] sack_sync_reg;
    logic [2:0] sreq_sync_reg;
    assign live_stat = {act_cnt_reg, act_row[ROW_W-1 -: 3], term_applied,
                        pwr_reg, open_reg};

    always_ff @(posedge mem_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            sack_sync_reg <= 2'h0;
            sreq_reg <= 1'b0;
            shadow_reg <= 32'h0000_0000;
        end else begin
            sack_sync_reg <= {sack_sync_reg[0], sack_reg};
            if (sack_sync_reg[1] == sreq_reg && shadow_reg != live_stat) begin
                shadow_reg <= live_stat;
                sreq_reg <= ~sreq_reg;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sreq_sync_reg <= 3'h0;
            sack_reg <= 1'b0;
            hstat_reg <= 32'h0000_0000;
        end else begin
            sreq_sync_reg <= {sreq_sync_reg[1:0], sreq_reg};
            if (sreq_sync_reg[2] != sreq_sync_reg[1]) begin
                hstat_reg <= shadow_reg;
            end
            sack_reg <= sreq_sync_reg[2];
        end
    end

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    logic aphase, wr_pend_reg;
    logic [7:0] wr_ofs_reg;
    assign aphase = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_ofs_reg <= 8'h00;
        end else begin
            wr_pend_reg <= aphase && hwrite;
            wr_ofs_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= SCC_MODE_RST[SCC_MODE_W-1:0];
            mode_tgl_reg <= 1'b0;
        end else if (wr_pend_reg && wr_ofs_reg == SCC_MODE_OFS) begin
            mode_reg <= hwdata[SCC_MODE_W-1:0];
            mode_tgl_reg <= ~mode_tgl_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (aphase && !hwrite) begin
            case (haddr[7:0])
                SCC_MODE_OFS: hrdata <= {22'h00_0000, mode_reg};
                SCC_STAT_OFS: hrdata <= hstat_reg;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : scc_top
`default_nettype wire

// >>> tb/scc_chk.sv
// Assertions on the memory-side pins and decoded outputs
`timescale 1ns/10ps
`default_nettype none
module scc_chk import scc_pkg::*; #(
    parameter int ROW_W = 17
) (
    // Clock and reset
    input wire logic hresetn, mem_clk,
    // Pins from the controller
    input wire logic clock_gate, rank_select_n, activate_input_n,
    input wire logic row_strobe_or_addr16, column_strobe_or_addr15,
    input wire logic write_cmd_or_addr14, termination_enable_in,
    input wire logic [1:0] bank_group, bank_addr,
    input wire logic [13:0] addr,
    // Enables and decoded commands
    input wire logic int_clk_en, cmd_buf_en, clk_buf_en, term_buf_en,
    input wire logic out_drv_en, term_applied, burst_chop, cmd_activate,
    input wire logic cmd_read, cmd_write, cmd_precharge, cmd_refresh,
    input wire logic cmd_mode_set,
    input wire logic [ROW_W-1:0] act_row,
    input wire logic [3:0] act_bank
);
    wire logic [2:0] code = {row_strobe_or_addr16, column_strobe_or_addr15,
        write_cmd_or_addr14};
    wire logic [3:0] bk = {bank_group, bank_addr};
    wire logic [5:0] cmdv = {cmd_activate, cmd_read, cmd_write,
        cmd_precharge, cmd_refresh, cmd_mode_set};
    default clocking cb @(posedge mem_clk); endclocking
    default disable iff (!hresetn);
    a_read_decode: assert property (cmd_read |->
        !$past(rank_select_n, 2) && $past(activate_input_n, 2) &&
        $past(code, 2) == SCC_CMD_RD) else $error("read without read code");
    a_write_decode: assert property (cmd_write |->
        !$past(rank_select_n, 2) && $past(activate_input_n, 2) &&
        $past(code, 2) == SCC_CMD_WR) else $error("write without code");
    a_act_decode: assert property (cmd_activate |->
        !$past(rank_select_n, 2) && !$past(activate_input_n, 2) &&
        act_row == ROW_W'({$past(code, 2), $past(addr, 2)}) &&
        act_bank == $past(bk, 2)) else $error("activate fields wrong");
    a_cs_mask: assert property ($past(rank_select_n, 2) |->
        cmdv == 6'h00) else $error("command while deselected");
    a_cmd_onehot: assert property ($onehot0(cmdv))
        else $error("two commands at once");
    a_gated_refuse: assert property (cmdv != 6'h00 |->
        $past(clock_gate, 3)) else $error("command while clock gated");
    a_gate_low_off: assert property ((!clock_gate) [*3] |->
        !int_clk_en && !out_drv_en && !cmd_buf_en)
        else $error("enables still on with gate low");
    a_gate_high_on: assert property (clock_gate [*8] |->
        int_clk_en && cmd_buf_en && out_drv_en && clk_buf_en)
        else $error("enables off with gate high");
    a_buf_pair: assert property (clk_buf_en == term_buf_en)
        else $error("clock and termination buffers differ");
    a_self_ref_buf: assert property (!clk_buf_en |->
        !cmd_buf_en && !int_clk_en) else $error("buffers on in self refresh");
    a_term_off: assert property ((!termination_enable_in) [*4] |->
        !term_applied) else $error("termination without input");
    a_sref_entry: assert property ($fell(clk_buf_en) |->
        $past(clock_gate, 3) && !$past(clock_gate, 2) &&
        !$past(rank_select_n, 2) && $past(activate_input_n, 2) &&
        $past(code, 2) == SCC_CMD_REF)
        else $error("self refresh without entry command");
    c_activate: cover property (cmd_activate);
    c_chop_read: cover property (cmd_read ##1 burst_chop);
    c_self_ref: cover property (!clk_buf_en);
    c_term: cover property (term_applied);
endmodule : scc_chk
`default_nettype wire

// >>> tb/scc_ctrl_model.sv
// Memory controller model driving the pins on the true clock
`timescale 1ns/10ps
`default_nettype none
module scc_ctrl_model (
    // Requests from the bench
    input wire logic mem_clk, rq_v, rq_cs_n, rq_act_n, cke_lvl, odt_lvl,
    input wire logic [2:0] rq_code,
    input wire logic [13:0] rq_addr,
    input wire logic [3:0] rq_bank,
    // Memory pins
    output logic clock_complement, clock_gate, rank_select_n,
    output logic activate_input_n, termination_enable_in,
    output logic [2:0] code,
    output logic [13:0] addr,
    output logic [3:0] bank,
    // Refresh interval watch
    output logic ref_late
);
    assign clock_complement = ~mem_clk;
    initial begin
        {clock_gate, termination_enable_in, ref_late} = 3'b000;
        {rank_select_n, activate_input_n} = 2'b11;
        {code, addr, bank} = '0;
    end
    // Pins change just after the rise, stable at the next crossing
    always @(posedge mem_clk) begin
        clock_gate <= cke_lvl;
        termination_enable_in <= odt_lvl;
        if (rq_v && (cke_lvl || clock_gate)) begin
            rank_select_n <= rq_cs_n;
            activate_input_n <= rq_act_n;
            {code, addr, bank} <= {rq_code, rq_addr, rq_bank};
        end else begin
            rank_select_n <= 1'b1;
            activate_input_n <= 1'b1;
            {code, addr, bank} <= ~{code, addr, bank};
        end
    end
    // Age cleared by a refresh code or by a gated clock
    localparam int REF_GAP = 7800 / 15;
    int ref_age = 0;
    always @(posedge mem_clk) begin
        if (!clock_gate || (!rank_select_n && activate_input_n &&
            code == 3'h1)) begin
            ref_age <= 0;
        end else begin
            ref_age <= ref_age + 1;
        end
        ref_late <= ref_late || ref_age > REF_GAP;
    end
endmodule : scc_ctrl_model
`default_nettype wire

// >>> tb/test_sdram_command_control_inputs.sv
// Self-checking bench for the command control input front end
`timescale 1ns/10ps
`default_nettype none
module test_sdram_command_control_inputs import scc_pkg::*;;
    logic hclk = 1'b0, mem_clk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
    logic hwrite = 1'b0, hreadyout, hresp, rq_v = 1'b0, rq_cs_n = 1'b1;
    logic rq_act_n = 1'b1, cke_lvl = 1'b1, odt_lvl = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, rq_code = 3'h7, code;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, m;
    logic [13:0] rq_addr = 14'h0, addr;
    logic [3:0] rq_bank = 4'h0, bank, act_bank;
    logic clock_complement, clock_gate, rank_select_n, activate_input_n;
    logic termination_enable_in, int_clk_en, cmd_buf_en, clk_buf_en;
    logic term_buf_en, out_drv_en, term_applied, burst_chop, cmd_activate;
    logic cmd_read, cmd_write, cmd_precharge, cmd_refresh, cmd_mode_set;
    logic [16:0] act_row;
    logic [4:0] additive_latency;
    logic [5:0] seen;
    logic ref_late;
    logic [15:0] lf = 16'h1629;
    int err_total = 0, checks = 0;
    always #20 hclk = ~hclk;
    always #7.5 mem_clk = ~mem_clk;
    scc_top u_scc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mem_clk(mem_clk),
        .clock_complement(clock_complement), .clock_gate(clock_gate),
        .rank_select_n(rank_select_n), .activate_input_n(activate_input_n),
        .row_strobe_or_addr16(code[2]), .column_strobe_or_addr15(code[1]),
        .write_cmd_or_addr14(code[0]), .bank_group(bank[3:2]),
        .termination_enable_in(termination_enable_in), .addr(addr),
        .bank_addr(bank[1:0]), .int_clk_en(int_clk_en),
        .cmd_buf_en(cmd_buf_en), .clk_buf_en(clk_buf_en),
        .term_buf_en(term_buf_en), .out_drv_en(out_drv_en),
        .term_applied(term_applied), .cmd_activate(cmd_activate),
        .cmd_read(cmd_read), .cmd_write(cmd_write),
        .cmd_precharge(cmd_precharge), .cmd_refresh(cmd_refresh),
        .cmd_mode_set(cmd_mode_set), .burst_chop(burst_chop),
        .act_row(act_row), .act_bank(act_bank),
        .additive_latency(additive_latency));
    scc_ctrl_model u_scc_ctrl_model (.mem_clk(mem_clk), .rq_v(rq_v),
        .rq_cs_n(rq_cs_n), .rq_act_n(rq_act_n), .cke_lvl(cke_lvl),
        .odt_lvl(odt_lvl), .rq_code(rq_code), .rq_addr(rq_addr),
        .rq_bank(rq_bank), .clock_complement(clock_complement),
        .clock_gate(clock_gate), .rank_select_n(rank_select_n),
        .activate_input_n(activate_input_n), .code(code), .addr(addr),
        .termination_enable_in(termination_enable_in), .bank(bank),
        .ref_late(ref_late));
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx
    function automatic logic [5:0] cexp(input logic [2:0] c);
        case (c)
            SCC_CMD_MRS: return 6'h01;
            SCC_CMD_REF: return 6'h02;
            SCC_CMD_PRE: return 6'h04;
            SCC_CMD_WR: return 6'h08;
            SCC_CMD_RD: return 6'h10;
            default: return 6'h00;
        endcase
    endfunction : cexp
    function automatic logic [4:0] aexp(input logic [1:0] a,
        input logic [4:0] r);
        return (a == SCC_AL_RL1) ? r - 5'h1 :
            (a == SCC_AL_RL2) ? r - 5'h2 : 5'h0;
    endfunction : aexp
    task automatic finish_test;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic check(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic ahb(input logic w, input logic [31:0] a, d,
        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 99);
        r = hrdata;
        if (n >= 99) begin err_total++; finish_test(); end
    endtask : ahb
    task automatic stat;
        repeat (8) @(posedge hclk);
        ahb(1'b0, 32'(SCC_STAT_OFS), 32'h0, rd);
    endtask : stat
    task automatic lk(input logic cs, input logic ac, input logic [2:0] c,
        input logic [13:0] a, input logic [3:0] b, input logic ck);
        @(posedge mem_clk);
        {rq_v, rq_cs_n, rq_act_n, rq_code} <= {1'b1, cs, ac, c};
        {rq_addr, rq_bank, cke_lvl} <= {a, b, ck};
        @(posedge mem_clk);
        rq_v <= 1'b0;
        seen = 6'h00;
        repeat (6) begin
            @(posedge mem_clk);
            #1 seen = seen | {cmd_activate, cmd_read, cmd_write,
                cmd_precharge, cmd_refresh, cmd_mode_set};
        end
    endtask : lk
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'(SCC_MODE_OFS), 32'h0, rd);
        check("mode", rd, SCC_MODE_RST);
        ahb(1'b1, 32'h10, 32'hffff_ffff, rd);
        ahb(1'b0, 32'h10, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        stat();
        check("pwr", 32'(rd[19:16]), 32'(SCC_PWR_ON));
        for (int i = 0; i < 3; i++) begin
            lf = nx(lf);
            m = {22'h0, lf[4:0] | 5'h04, 2'(i), 2'(i), 1'b1};
            ahb(1'b1, 32'(SCC_MODE_OFS), m, rd);
            repeat (4) @(posedge hclk);
            check("al", 32'(additive_latency),
                32'(aexp(m[2:1], m[9:5])));
            lk(1'b0, 1'b1, SCC_CMD_RD, lf[15:2], lf[3:0], 1'b1);
            check("read", 32'(seen), 32'h10);
            check("chop", 32'(burst_chop),
                32'(i == 2 || (i == 1 && !lf[14])));
        end
        for (int i = 0; i < 2; i++) begin
            lf = nx(lf);
            lk(1'b0, 1'b0, lf[2:0], lf[15:2], lf[7:4], 1'b1);
            check("act", 32'(seen), 32'h20);
            check("row", 32'(act_row), 32'({lf[2:0], lf[15:2]}));
            check("bank", 32'(act_bank), 32'(lf[7:4]));
        end
        lk(1'b1, 1'b0, 3'h1, 14'h0, 4'h0, 1'b1);
        check("masked", 32'(seen), 32'h0);
        lk(1'b1, 1'b1, 3'h7, 14'h0, 4'h0, 1'b0);
        stat();
        check("open", 32'(rd[lf[7:4]]), 32'h1);
        check("count", 32'(rd[31:24]), 32'h2);
        check("rowhi", 32'(rd[23:21]), 32'(lf[2:0]));
        check("apd", 32'(rd[19:16]), 32'(SCC_PWR_APD));
        check("pdbuf", 32'({int_clk_en, out_drv_en, cmd_buf_en,
            clk_buf_en, term_buf_en}), 32'h3);
        lk(1'b1, 1'b1, 3'h7, 14'h0, 4'h0, 1'b1);
        lk(1'b0, 1'b1, SCC_CMD_PRE, 14'h0400, 4'h0, 1'b1);
        for (int c = 0; c < 8; c++) begin
            lk(1'b0, 1'b1, 3'(c), 14'h0, 4'h0, 1'b1);
            check("cmd", 32'(seen), 32'(cexp(3'(c))));
        end
        lk(1'b1, 1'b1, 3'h7, 14'h0, 4'h0, 1'b0);
        stat();
        check("ppd", 32'(rd[19:0]), 32'(SCC_PWR_PPD) << 16);
        lk(1'b1, 1'b1, 3'h7, 14'h0, 4'h0, 1'b1);
        lk(1'b0, 1'b1, SCC_CMD_REF, 14'h0, 4'h0, 1'b0);
        stat();
        check("sref", 32'(rd[19:16]), 32'(SCC_PWR_SREF));
        check("srbuf", 32'({cmd_buf_en, clk_buf_en, term_buf_en}), 32'h0);
        lk(1'b1, 1'b1, 3'h7, 14'h0, 4'h0, 1'b1);
        stat();
        check("exit", 32'(rd[19:16]), 32'(SCC_PWR_ON));
        check("onbuf", 32'({int_clk_en, out_drv_en, cmd_buf_en,
            clk_buf_en, term_buf_en}), 32'h1f);
        odt_lvl <= 1'b1;
        stat();
        check("term", 32'({term_applied, rd[20]}), 32'h3);
        ahb(1'b1, 32'(SCC_MODE_OFS), m & 32'hffff_fffe, rd);
        stat();
        check("noterm", 32'({term_applied, rd[20]}), 32'h0);
        check("refgap", 32'(ref_late), 32'h0);
        finish_test();
    end
endmodule : test_sdram_command_control_inputs
bind scc_top scc_chk #(.ROW_W(ROW_W)) u_scc_chk (.*);
`default_nettype wire
